// >>> dssb_pkg.sv
// Package: status byte layout, reason codes and behaviour notes for the drive status bytes
// Notes on behaviour
// R01 - Unavailable bit tracks inoperable drive; each change raises the pending event latch.
// R02 - Index, sector and clocks are meaningless while unavailable; host ignores them.
// R03 - Protocol error on parity, both strobes idle, wrong direction, repeated cycles.
// R04 - Erroneous exchange is not executed; read-direction second byte returns general status.
// R05 - Protocol error bit cleared only by fault flush; detection raises the latch.
// R06 - Bad opcode on unimplemented code or opcode parity; parity also marks protocol error.
// R07 - Bad operand on range, illegal value or parity; parity also marks protocol error.
// R08 - Status bits 4 and 5 are OR summaries of the error and event bytes.
// R09 - Executing bit stays high while any long command runs, independent of busy.
// R10 - Completed bit set on long command success, raises latch, cleared by event flush.
// R11 - Positioning error set on failed seek, rezero, landing or offset; raises latch.
// R12 - Positioning error needing rezero clears only on successful rezero, else fault flush.
// R13 - Refused read or write window sets error bits 1 and 5 together; code detects a refused write window only.
// R14 - Read/write section fault sets error bit 1 only; fault flush clears; raises latch.
// R15 - Supply fault set on bad voltage; flush clears only once gone; raises latch.
// R16 - Access denied on gated access to forbidden track; fault flush clears; raises latch.
// R17 - Rotation error outside tolerance; flush clears once in tolerance; raises latch.
// R18 - Refused command on interlock or sequence error; fault flush clears.
// R19 - Misc error for other faults; flush clears only once gone; raises latch.
// R20 - Event bits 2,4,6 self clear; 0,1,3,5,7 event flush only and raise latch.
// R21 - Bits of unimplemented or undefined options always read zero.
// R22 - Busy, unavailable, executing follow the motor and operation state table.
// R23 - Availability changed bit set on unavailable change; event flush clears; raises latch.
// R24 - Fault flush does not drop attention while the causing error persists.
// R25 - Pending latch is sticky; flushes clear it only when no covered source remains.
`default_nettype none
package dssb_pkg;
  // ==========================================================
  // Bit positions
  localparam int GS_UNAVAIL = 0;
  localparam int GS_PROTO = 1;
  localparam int GS_BADOP = 2;
  localparam int GS_BADARG = 3;
  localparam int GS_ERRSUM = 4;
  localparam int GS_EVTSUM = 5;
  localparam int GS_EXEC = 6;
  localparam int GS_DONE = 7;
  localparam int ER_POS = 0;
  localparam int ER_RW = 1;
  localparam int ER_SUPPLY = 2;
  localparam int ER_ACCESS = 3;
  localparam int ER_SPEED = 4;
  localparam int ER_REFUSE = 5;
  localparam int ER_MISC = 6;
  localparam int ER_VENDOR = 7;
  localparam int EV_INIT = 0;
  localparam int EV_AVAIL = 1;
  localparam int EV_RSVHERE = 2;
  localparam int EV_FORCED = 3;
  localparam int EV_RSVALT = 4;
  localparam int EV_TABLE = 5;
  localparam int EV_WPROT = 6;
  localparam int EV_VENDOR = 7;
  // ==========================================================
  // Reset values and option masks
  localparam logic [7:0] GS_RESET = 8'h01;
  localparam logic [7:0] ER_RESET = 8'h00;
  localparam logic [7:0] EV_RESET = 8'h00;
  localparam logic [7:0] EV_STICKY_MASK = 8'hab;
  localparam logic [7:0] EV_SELF_MASK = 8'h54;
  localparam logic [7:0] ER_LATCH_MASK = 8'hdf;
  // ==========================================================
  // Drive activity modes
  typedef enum logic [7:0] {
    DSSB_IDLE = 8'h01,
    DSSB_SPINUP = 8'h02,
    DSSB_SPINDOWN = 8'h04,
    DSSB_STOPPED = 8'h08,
    DSSB_NOMEDIA = 8'h10,
    DSSB_SEEK = 8'h20,
    DSSB_DIAG = 8'h40,
    DSSB_RW = 8'h80
  } dssb_mode_t;
  // Control bus cycle report from the handshake logic
  typedef struct packed {
    logic cycle;
    logic opcodeStrobe;
    logic operandStrobe;
    logic hostDrives;
    logic parityErr;
    logic opcodeKnown;
    logic wantHostDrives;
    logic operandBad;
  } dssb_bus_t;
  // Drive condition inputs
  typedef struct packed {
    logic seekFail;
    logic seekNeedsRezero;
    logic rezeroOk;
    logic longDone;
    logic readGate;
    logic writeGate;
    logic writeDisabled;
    logic headsOffset;
    logic multiHead;
    logic noWriteCurrent;
    logic supplyBad;
    logic readForbidden;
    logic writeForbidden;
    logic speedBad;
    logic interlock;
    logic miscErr;
    logic initDone;
    logic tableModified;
    logic inWriteProt;
  } dssb_cond_t;
endpackage
`default_nettype wire

// >>> dssb_status.sv
// Module: drive status, error detail and event detail bytes with pending event latch
`default_nettype none
module dssb_status
  import dssb_pkg::*;
#(
  parameter bit POWER_CHECK = 1'b1,
  parameter bit SPEED_CHECK = 1'b1,
  parameter bit OPERAND_CHECK = 1'b1
)(
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // Sync reset, active high
  input wire logic ce, // Clock enable
  input wire dssb_mode_t mode, // Drive activity mode
  input wire dssb_bus_t bus, // Control bus cycle report
  input wire dssb_cond_t cond, // Drive conditions
  input wire logic faultFlush, // Fault flush command pulse
  input wire logic eventFlush, // Event flush command pulse
  output logic [7:0] statusByte, // Device status byte
  output logic [7:0] errorByte, // Error detail byte
  output logic [7:0] eventByte, // Event detail byte
  output logic busy, // Busy interface signal
  output logic signalsValid, // Index/sector/clock outputs valid
  output logic execCommand, // Exchange accepted for execution
  output logic returnStatus, // Return status byte on bad read exchange
  output logic pendingEvent // Pending event latch
);
  logic [7:0] gsBits_r;
  logic [7:0] errorByte_r;
  logic [7:0] eventByte_r;
  logic pending_r;
  logic lastOpcode_r;
  logic lastOperand_r;
  logic opcodeBad_r;
  logic rezeroNeeded_r;
  logic busyOut_r;
  logic unavailNxt;
  logic execNxt;
  logic protoErr;
  logic badOp;
  logic badArg;
  logic windowRefused;
  logic rwFault;
  logic accessDenied;
  logic [7:0] gsNxt;
  logic [7:0] errNxt;
  logic [7:0] evNxt;
  logic [7:0] gsRise;
  logic [7:0] erRise;
  logic [7:0] evRise;
  logic availToggle;
  logic errPersist;

  // Zero-to-one edges of a byte
  function automatic logic [7:0] rising(input logic [7:0] oldv, input logic [7:0] newv);
    rising = newv & ~oldv;
  endfunction

  // ==========================================================
  // Activity mode decoding
  always_comb
  begin
    unavailNxt = 1'b0;
    execNxt = 1'b0;
    case (mode)
      DSSB_IDLE:
      begin
        unavailNxt = 1'b0; // [R22]
        execNxt = 1'b0;
      end
      DSSB_SPINUP, DSSB_SPINDOWN:
      begin
        unavailNxt = 1'b1; // [R22]
        execNxt = 1'b1;
      end
      DSSB_STOPPED, DSSB_NOMEDIA:
      begin
        unavailNxt = 1'b1; // [R01] [R22]
        execNxt = 1'b0;
      end
      DSSB_SEEK:
      begin
        unavailNxt = 1'b0; // [R22]
        execNxt = 1'b1; // [R09]
      end
      DSSB_DIAG:
      begin
        unavailNxt = gsBits_r[GS_UNAVAIL];
        execNxt = 1'b1; // [R22]
      end
      DSSB_RW:
      begin
        unavailNxt = 1'b0; // [R22]
        execNxt = 1'b0;
      end
      default:
      begin
        unavailNxt = 1'b1;
        execNxt = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Control bus checking
  always_comb
  begin
    protoErr = 1'b0;
    if (bus.cycle)
    begin
      if (bus.parityErr)
        protoErr = 1'b1; // [R03]
      if (!bus.opcodeStrobe && !bus.operandStrobe)
        protoErr = 1'b1; // [R03]
      if (bus.operandStrobe && (bus.hostDrives != bus.wantHostDrives))
        protoErr = 1'b1; // [R03]
      if (bus.operandStrobe && lastOperand_r)
        protoErr = 1'b1; // [R03]
      if (bus.opcodeStrobe && lastOpcode_r)
        protoErr = 1'b1; // [R03]
    end
  end

  assign badOp = bus.cycle && bus.opcodeStrobe && (!bus.opcodeKnown || bus.parityErr); // [R06]
  // Operand checks are optional; parity on the operand is checked anyway
  assign badArg = bus.cycle && bus.operandStrobe
    && ((OPERAND_CHECK && bus.operandBad) || bus.parityErr); // [R07]

  // Sequence tracking for repeated cycle detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lastOpcode_r <= 1'b0;
      lastOperand_r <= 1'b0;
    end
    else if (ce && bus.cycle)
    begin
      lastOpcode_r <= bus.opcodeStrobe && !bus.operandStrobe;
      lastOperand_r <= bus.operandStrobe && !bus.opcodeStrobe;
    end
  end

  // Operand of an unknown or corrupt opcode must not start anything
  always_ff @(posedge clk)
  begin
    if (rst)
      opcodeBad_r <= 1'b0;
    else if (ce && bus.cycle && bus.opcodeStrobe)
      opcodeBad_r <= badOp; // [R06]
  end

  // An error anywhere in the exchange suppresses execution
  // Nothing is taken while the enable is low, so no answer either
  assign execCommand = ce && bus.cycle && bus.operandStrobe && !protoErr
    && !gsBits_r[GS_PROTO] && !opcodeBad_r && !badArg; // [R04]
  assign returnStatus = ce && bus.cycle && bus.operandStrobe && !bus.hostDrives
    && (protoErr || gsBits_r[GS_PROTO]); // [R04]

  // ==========================================================
  // Error detail byte
  assign windowRefused = cond.writeGate && (cond.writeDisabled || cond.headsOffset); // [R13]
  assign rwFault = cond.multiHead || (cond.writeGate && cond.noWriteCurrent)
    || (cond.readGate && cond.writeGate); // [R14]
  assign accessDenied = (cond.writeGate && cond.writeForbidden)
    || (cond.readGate && cond.readForbidden); // [R16]

  always_comb
  begin
    errNxt = errorByte_r;
    if (faultFlush)
    begin
      if (!rezeroNeeded_r)
        errNxt[ER_POS] = 1'b0; // [R12]
      errNxt[ER_RW] = 1'b0; // [R14]
      errNxt[ER_ACCESS] = 1'b0; // [R16]
      errNxt[ER_REFUSE] = 1'b0; // [R18]
      if (!cond.supplyBad)
        errNxt[ER_SUPPLY] = 1'b0; // [R15]
      if (!cond.speedBad)
        errNxt[ER_SPEED] = 1'b0; // [R17]
      if (!cond.miscErr)
        errNxt[ER_MISC] = 1'b0; // [R19]
    end
    if (cond.rezeroOk)
      errNxt[ER_POS] = 1'b0; // [R12]
    // Sets are applied last so a same-cycle event beats the flush
    if (cond.seekFail)
      errNxt[ER_POS] = 1'b1; // [R11]
    if (windowRefused)
    begin
      errNxt[ER_RW] = 1'b1; // [R13]
      errNxt[ER_REFUSE] = 1'b1; // [R13]
    end
    if (rwFault)
      errNxt[ER_RW] = 1'b1; // [R14]
    if (POWER_CHECK && cond.supplyBad)
      errNxt[ER_SUPPLY] = 1'b1; // [R15]
    if (accessDenied)
      errNxt[ER_ACCESS] = 1'b1; // [R16]
    if (SPEED_CHECK && cond.speedBad)
      errNxt[ER_SPEED] = 1'b1; // [R17]
    if (cond.interlock)
      errNxt[ER_REFUSE] = 1'b1; // [R18]
    if (cond.miscErr)
      errNxt[ER_MISC] = 1'b1; // [R19]
    errNxt[ER_VENDOR] = 1'b0; // [R21]
    if (!POWER_CHECK)
      errNxt[ER_SUPPLY] = 1'b0; // [R21]
    if (!SPEED_CHECK)
      errNxt[ER_SPEED] = 1'b0; // [R21]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rezeroNeeded_r <= 1'b0;
    else if (ce)
    begin
      if (cond.seekFail)
        rezeroNeeded_r <= cond.seekNeedsRezero; // [R12]
      else if (cond.rezeroOk)
        rezeroNeeded_r <= 1'b0;
    end
  end

  // ==========================================================
  // Event detail byte
  assign availToggle = unavailNxt != gsBits_r[GS_UNAVAIL];

  always_comb
  begin
    evNxt = eventByte_r & EV_STICKY_MASK;
    if (eventFlush)
      evNxt = 8'h00; // [R20]
    if (cond.initDone)
      evNxt[EV_INIT] = 1'b1;
    if (availToggle)
      evNxt[EV_AVAIL] = 1'b1; // [R23]
    if (cond.tableModified)
      evNxt[EV_TABLE] = 1'b1;
    // Self clearing level; single port, so reservation bits stay zero
    evNxt[EV_WPROT] = cond.inWriteProt || cond.writeDisabled; // [R20]
    evNxt[EV_RSVHERE] = 1'b0; // [R21]
    evNxt[EV_RSVALT] = 1'b0; // [R21]
    evNxt[EV_FORCED] = 1'b0; // [R21]
    evNxt[EV_VENDOR] = 1'b0; // [R21]
  end

  // ==========================================================
  // Device status byte
  always_comb
  begin
    gsNxt = gsBits_r;
    gsNxt[GS_UNAVAIL] = unavailNxt; // [R01]
    gsNxt[GS_EXEC] = execNxt; // [R09]
    if (faultFlush)
    begin
      gsNxt[GS_PROTO] = 1'b0; // [R05]
      gsNxt[GS_BADOP] = 1'b0; // [R06]
      gsNxt[GS_BADARG] = 1'b0; // [R07]
    end
    if (eventFlush)
      gsNxt[GS_DONE] = 1'b0; // [R10]
    if (protoErr || (badOp && bus.parityErr) || (badArg && bus.parityErr))
      gsNxt[GS_PROTO] = 1'b1; // [R03] [R06] [R07]
    if (badOp)
      gsNxt[GS_BADOP] = 1'b1; // [R06]
    if (badArg)
      gsNxt[GS_BADARG] = 1'b1; // [R07]
    if (cond.longDone)
      gsNxt[GS_DONE] = 1'b1; // [R10]
    gsNxt[GS_ERRSUM] = 1'b0;
    gsNxt[GS_EVTSUM] = 1'b0;
  end

  assign gsRise = rising(gsBits_r, gsNxt);
  assign erRise = rising(errorByte_r, errNxt);
  assign evRise = rising(eventByte_r, evNxt);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gsBits_r <= GS_RESET;
      errorByte_r <= ER_RESET;
      eventByte_r <= EV_RESET;
    end
    else if (ce)
    begin
      gsBits_r <= gsNxt;
      errorByte_r <= errNxt;
      eventByte_r <= evNxt;
    end
  end

  // ==========================================================
  // Pending event latch
  // Persisting fault sources hold the latch through a fault flush
  assign errPersist = gsNxt[GS_PROTO] || gsNxt[GS_BADOP] || gsNxt[GS_BADARG]
    || |(errNxt & ER_LATCH_MASK); // [R24]

  always_ff @(posedge clk)
  begin
    if (rst)
      pending_r <= 1'b0;
    else if (ce)
    begin
      if (availToggle || gsRise[GS_PROTO] || gsRise[GS_BADOP] || gsRise[GS_BADARG]
          || gsRise[GS_DONE] || |(erRise & ER_LATCH_MASK)
          || |(evRise & EV_STICKY_MASK)
          || (protoErr && gsBits_r[GS_PROTO])) // [R01] [R05] [R10] [R11] [R14] [R20] [R25]
        pending_r <= 1'b1;
      else if ((faultFlush || eventFlush) && !errPersist && !(|(evNxt & EV_STICKY_MASK))
               && !gsNxt[GS_DONE])
        pending_r <= 1'b0; // [R24] [R25]
    end
  end

  // Busy is vendor dependent in active modes; we assert it there
  always_ff @(posedge clk)
  begin
    if (rst)
      busyOut_r <= 1'b0;
    else if (ce)
      busyOut_r <= (mode != DSSB_IDLE) && (mode != DSSB_STOPPED)
        && (mode != DSSB_NOMEDIA); // [R22]
  end

  // ==========================================================
  // Outputs
  always_comb
  begin
    statusByte = gsBits_r;
    statusByte[GS_ERRSUM] = |errorByte_r; // [R08]
    statusByte[GS_EVTSUM] = |eventByte_r; // [R08]
  end
  assign errorByte = errorByte_r;
  assign eventByte = eventByte_r;
  assign busy = busyOut_r;
  assign signalsValid = !gsBits_r[GS_UNAVAIL]; // [R02]
  assign pendingEvent = pending_r;
endmodule
`default_nettype wire

// >>> dssb_status_asserts.sv
// Checker: concurrent assertions on the drive status byte ports
`default_nettype none
module dssb_status_chk
  import dssb_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic ce, // Enable
  input wire dssb_mode_t mode, // Mode
  input wire dssb_bus_t bus, // Bus report
  input wire dssb_cond_t cond, // Conditions
  input wire logic faultFlush, // Fault flush
  input wire logic eventFlush, // Event flush
  input wire logic [7:0] statusByte, // Status
  input wire logic [7:0] errorByte, // Errors
  input wire logic [7:0] eventByte, // Events
  input wire logic busy, // Busy
  input wire logic signalsValid, // Valid
  input wire logic execCommand, // Execute
  input wire logic returnStatus, // Return status
  input wire logic pendingEvent // Latch
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Assertions
  chk_err_summary: assert property (statusByte[GS_ERRSUM] == |errorByte)
    else $error("error summary bit wrong");
  chk_evt_summary: assert property (statusByte[GS_EVTSUM] == |eventByte)
    else $error("event summary bit wrong");
  chk_valid_flag: assert property (signalsValid == !statusByte[GS_UNAVAIL])
    else $error("signal valid flag wrong");
  chk_avail_event: assert property ($changed(statusByte[GS_UNAVAIL])
    |-> eventByte[EV_AVAIL] && pendingEvent)
    else $error("availability change not reported");
  chk_parity_proto: assert property (ce && bus.cycle && bus.parityErr
    |=> statusByte[GS_PROTO] && pendingEvent)
    else $error("parity error not flagged");
  chk_proto_hold: assert property (statusByte[GS_PROTO] && !(ce && faultFlush)
    |=> statusByte[GS_PROTO])
    else $error("protocol error bit dropped");
  chk_done_hold: assert property (statusByte[GS_DONE] && !(ce && eventFlush)
    |=> statusByte[GS_DONE])
    else $error("completed bit dropped");
  chk_no_exec: assert property (execCommand
    |-> ce && bus.cycle && !bus.parityErr && !returnStatus && !statusByte[GS_PROTO])
    else $error("erroneous exchange executed");
  chk_ret_dir: assert property (returnStatus |-> bus.cycle && !bus.hostDrives)
    else $error("status returned on host write");
  chk_supply_hold: assert property (errorByte[ER_SUPPLY] && cond.supplyBad
    |=> errorByte[ER_SUPPLY])
    else $error("supply fault cleared while present");
  chk_stop_mode: assert property (ce && mode == DSSB_STOPPED
    |=> !busy && statusByte[GS_UNAVAIL] && !statusByte[GS_EXEC])
    else $error("stopped mode signals wrong");
  cover property (execCommand);
  cover property (returnStatus);
  cover property ($rose(statusByte[GS_DONE]));
endmodule
`default_nettype wire

// >>> dssb_host.sv
// Host controller model: control bus cycles and flush commands
`default_nettype none
module dssb_host
  import dssb_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic execCommand, // Exchange accepted
  input wire logic returnStatus, // Status returned
  output var dssb_bus_t bus, // Bus cycle report
  output var logic faultFlush, // Fault flush pulse
  output var logic eventFlush // Event flush pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    bus = '0;
    faultFlush = 1'b0;
    eventFlush = 1'b0;
  end
  // ==========================================================
  // One byte per call; only handshake results sampled, never index or clocks
  task automatic cyc(input logic op, input logic hd, input logic pe, input logic kn,
    input logic wh, output logic ex, output logic rs);
    @(negedge clk);
    bus <= '{1'b1, op, ~op, hd, pe, kn, wh, 1'b0};
    #1;
    ex = execCommand;
    rs = returnStatus;
    @(negedge clk);
    bus <= '0;
  endtask
  task automatic flush(input logic f, input logic e);
    @(negedge clk);
    faultFlush <= f;
    eventFlush <= e;
    @(negedge clk);
    faultFlush <= 1'b0;
    eventFlush <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Testbench: drive status bytes exercised by a host controller model
`default_nettype none
module tb;
  import dssb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {dssb_mode_t m; logic [2:0] e;} dssb_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  dssb_mode_t mode = DSSB_IDLE;
  dssb_cond_t cond = '0;
  dssb_bus_t bus;
  logic faultFlush, eventFlush, busy, signalsValid, execCommand, returnStatus, pendingEvent;
  logic [7:0] statusByte, errorByte, eventByte;
  logic ex, rs;
  int miscompares = 0;
  int n_compared = 0;
  // Busy, unavailable, executing per mode; diagnostics keep the seek value
  dssb_row_t rows [8] = '{'{DSSB_IDLE, 3'h0}, '{DSSB_SPINUP, 3'h7}, '{DSSB_SPINDOWN, 3'h7},
    '{DSSB_STOPPED, 3'h2}, '{DSSB_NOMEDIA, 3'h2}, '{DSSB_SEEK, 3'h5}, '{DSSB_DIAG, 3'h5},
    '{DSSB_RW, 3'h4}};
  always #20 clk = ~clk;
  dssb_status i_dut (.clk(clk), .rst(rst), .ce(ce), .mode(mode), .bus(bus), .cond(cond),
    .faultFlush(faultFlush), .eventFlush(eventFlush), .statusByte(statusByte),
    .errorByte(errorByte), .eventByte(eventByte), .busy(busy), .signalsValid(signalsValid),
    .execCommand(execCommand), .returnStatus(returnStatus), .pendingEvent(pendingEvent));
  dssb_host i_host (.clk(clk), .execCommand(execCommand), .returnStatus(returnStatus),
    .bus(bus), .faultFlush(faultFlush), .eventFlush(eventFlush));
  // ==========================================================
  // Helpers
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chkByte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    ticks(3000);
    miscompares++;
    end_sim();
  end
  // ==========================================================
  // Sequence
  initial
  begin
    ticks(5);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      mode <= rows[i].m;
      ticks(3);
      chkByte({5'h00, busy, statusByte[GS_UNAVAIL], statusByte[GS_EXEC]},
        {5'h00, rows[i].e});
      chkBit(signalsValid, !rows[i].e[1]);
    end
    rst <= 1'b1;
    mode <= DSSB_IDLE;
    ticks(2);
    chkByte(statusByte, GS_RESET);
    chkByte(errorByte | eventByte, 8'h00);
    chkBit(busy | pendingEvent, 1'b0);
    rst <= 1'b0;
    ticks(1);
    chkByte(eventByte, 8'h02);
    chkByte(statusByte, 8'h20);
    chkBit(pendingEvent, 1'b1);
    i_host.flush(1'b0, 1'b1);
    chkByte(statusByte, 8'h00);
    chkBit(pendingEvent, 1'b0);
    i_host.cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, ex, rs);
    i_host.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, ex, rs);
    chkByte({6'h00, ex, rs}, 8'h02);
    i_host.cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, ex, rs);
    i_host.cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, ex, rs);
    chkByte(statusByte, 8'h02);
    i_host.cyc(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, ex, rs);
    chkByte({6'h00, ex, rs}, 8'h01);
    chkBit(pendingEvent, 1'b1);
    i_host.flush(1'b0, 1'b1);
    chkBit(statusByte[GS_PROTO], 1'b1);
    i_host.flush(1'b1, 1'b0);
    chkByte(statusByte, 8'h00);
    chkBit(pendingEvent, 1'b0);
    i_host.cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, ex, rs);
    i_host.cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, ex, rs);
    chkByte(statusByte, 8'h0e);
    chkBit(ex, 1'b0);
    i_host.flush(1'b1, 1'b0);
    chkByte(statusByte, 8'h00);
    i_host.cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, ex, rs);
    i_host.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, ex, rs);
    chkByte(statusByte, 8'h04);
    chkBit(ex, 1'b0);
    i_host.flush(1'b1, 1'b0);
    chkBit(pendingEvent, 1'b0);
    cond.writeGate <= 1'b1;
    cond.writeDisabled <= 1'b1;
    ticks(2);
    chkByte(errorByte, 8'h22);
    chkByte(eventByte, 8'h40);
    chkByte(statusByte, 8'h30);
    cond <= '0;
    ticks(2);
    chkByte(eventByte, 8'h00);
    i_host.flush(1'b1, 1'b0);
    chkByte(errorByte, 8'h00);
    chkBit(pendingEvent, 1'b0);
    cond.supplyBad <= 1'b1;
    ticks(2);
    i_host.flush(1'b1, 1'b0);
    chkByte(errorByte, 8'h04);
    chkBit(pendingEvent, 1'b1);
    cond.supplyBad <= 1'b0;
    i_host.flush(1'b1, 1'b0);
    chkByte(errorByte, 8'h00);
    cond.seekNeedsRezero <= 1'b1;
    cond.seekFail <= 1'b1;
    ticks(1);
    cond <= '0;
    i_host.flush(1'b1, 1'b0);
    chkByte(errorByte, 8'h01);
    cond.rezeroOk <= 1'b1;
    ticks(1);
    cond.rezeroOk <= 1'b0;
    ticks(1);
    chkByte(errorByte, 8'h00);
    cond.longDone <= 1'b1;
    ticks(1);
    cond.longDone <= 1'b0;
    i_host.flush(1'b1, 1'b0);
    chkBit(statusByte[GS_DONE], 1'b1);
    i_host.flush(1'b0, 1'b1);
    chkByte(statusByte, 8'h00);
    chkBit(pendingEvent, 1'b0);
    ce <= 1'b0;
    cond.miscErr <= 1'b1;
    ticks(2);
    chkByte(errorByte, 8'h00);
    ce <= 1'b1;
    cond.multiHead <= 1'b1;
    cond.readGate <= 1'b1;
    cond.readForbidden <= 1'b1;
    cond.speedBad <= 1'b1;
    cond.interlock <= 1'b1;
    cond.initDone <= 1'b1;
    cond.tableModified <= 1'b1;
    ticks(1);
    cond.initDone <= 1'b0;
    cond.tableModified <= 1'b0;
    ticks(1);
    chkByte(errorByte, 8'h7a);
    chkByte(eventByte, 8'h21);
    chkBit(pendingEvent, 1'b1);
    cond.multiHead <= 1'b0;
    cond.readGate <= 1'b0;
    cond.readForbidden <= 1'b0;
    cond.interlock <= 1'b0;
    i_host.flush(1'b1, 1'b0);
    chkByte(errorByte, 8'h50);
    chkBit(pendingEvent, 1'b1);
    cond <= '0;
    i_host.flush(1'b1, 1'b1);
    chkByte(errorByte | eventByte, 8'h00);
    chkBit(pendingEvent, 1'b0);
    end_sim();
  end
endmodule
bind dssb_status dssb_status_chk i_chk (.clk(clk), .rst(rst), .ce(ce), .mode(mode), .bus(bus),
  .cond(cond), .faultFlush(faultFlush), .eventFlush(eventFlush), .statusByte(statusByte),
  .errorByte(errorByte), .eventByte(eventByte), .busy(busy), .signalsValid(signalsValid),
  .execCommand(execCommand), .returnStatus(returnStatus), .pendingEvent(pendingEvent));
`default_nettype wire
